//--- verilog/board_health_monitor.sv
// Purpose: board_manager records, sampling, blink codes, watchdog
// Assumes: inputs synchronous to clk; nonvolatile backing external
// Notes:   counters load from the persist inputs at start
`timescale 1ns/1ps
`include "health_cfg.svh"
module board_health_monitor
   import health_pkg::*;
#(
   parameter int SAMPLE_CYCLES = `SAMPLE_CYC,
   parameter int SEC_CYCLES    = `SEC_CYC,
   parameter int BLINK_CYCLES  = `BLINK_CYC
)(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        load_persist,
   input  wire stat_t       persist_in,
   input  wire logic        running,
   input  wire logic        hw_reset_evt,
   input  wire logic        sw_reset_evt,
   input  wire logic        power_up_ok,
   input  wire logic        ext_reset_evt,
   input  wire logic        power_lost_evt,
   input  wire logic [7:0]  cpu_temp,
   input  wire logic [7:0]  brd_temp,
   input  wire logic        temp_valid,
   input  wire logic [15:0] adc_data [0:7],
   input  wire logic        fault_evt,
   input  wire logic [4:0]  fault_code,
   input  wire logic        undervolt,
   input  wire logic        supply_ok_4v2,
   input  wire logic        key_lock,
   input  wire req_t        req,
   output resp_t            resp,
   output stat_t            stat,
   output logic             status_indicator,
   output logic             watchdog_indicator,
   output logic             watchdog_restart
);
   typedef struct packed {
      stat_t       st;
      logic [31:0] sec_cnt;
      logic [5:0]  sec_in_min;
      logic [31:0] samp_cnt;
      logic [1:0]  samp_slot;
      logic [63:0] cur;
      logic [31:0] blink_cnt;
      logic [5:0]  blink_half;
      logic        led;
      logic        wd_on;
      logic [15:0] wd_reload;
      logic [15:0] wd_left;
      logic        wd_restart;
      logic        wd_pending;
      logic        wd_led;
      resp_t       rsp;
   } state_t;

   state_t      s_reg;
   state_t      s_next;
   logic [7:0]  cust_mem [0:`CUST_BYTES-1];
   logic [7:0]  key_mem  [0:`KEY_BYTES-1];
   logic [7:0]  mem_q;

   function automatic logic [7:0] hi(input logic [15:0] v);
      return v[15:8];
   endfunction : hi

   function automatic logic [7:0] lo(input logic [15:0] v);
      return v[7:0];
   endfunction : lo

   // end test shared by the second, sample and blink timers
   function automatic logic at_end(input logic [31:0] cnt, input int len);
      return cnt == 32'(len - 1);
   endfunction : at_end

   // blink halves taken by the pulses of one code
   function automatic logic [5:0] code_halves(input logic [4:0] code);
      return 6'({1'b0, code} * 2);
   endfunction : code_halves

   // store writes; key area refuses writes while locked
   always_ff @(posedge clk) begin
      if (req.valid && req.func == F_MEM_WR) begin
         if (req.key_area) begin
            if (!key_lock)
               key_mem[req.addr[6:0]] <= req.wdata;
         end else begin
            cust_mem[req.addr[9:0]] <= req.wdata;
         end
      end
   end
   assign mem_q = req.key_area ? key_mem[req.addr[6:0]]
                               : cust_mem[req.addr[9:0]];

   always_comb begin
      s_next = s_reg;
      s_next.rsp = '0;
      s_next.wd_restart = 1'b0;
      if (load_persist) begin
         s_next.st.run_minutes = persist_in.run_minutes;
         s_next.st.boot_count  = persist_in.boot_count;
         s_next.st.cpu_tmin    = persist_in.cpu_tmin;
         s_next.st.cpu_tmax    = persist_in.cpu_tmax;
         s_next.st.brd_tmin    = persist_in.brd_tmin;
         s_next.st.brd_tmax    = persist_in.brd_tmax;
      end
      // seconds and minutes
      if (running) begin
         if (at_end(s_reg.sec_cnt, SEC_CYCLES)) begin
            s_next.sec_cnt = '0;
            s_next.st.on_seconds = s_reg.st.on_seconds + 32'h1;
            if (s_reg.sec_in_min == 6'(`SEC_PER_MIN - 1)) begin
               s_next.sec_in_min = '0;
               s_next.st.run_minutes =
                  s_reg.st.run_minutes + 32'h1;
            end else begin
               s_next.sec_in_min = s_reg.sec_in_min + 6'h1;
            end
         end else begin
            s_next.sec_cnt = s_reg.sec_cnt + 32'h1;
         end
      end
      if (power_up_ok || hw_reset_evt || sw_reset_evt) begin
         s_next.st.on_seconds = '0;
         s_next.sec_cnt = '0;
      end
      if (hw_reset_evt || sw_reset_evt || power_up_ok)
         s_next.st.boot_count = s_reg.st.boot_count + 16'h1;
      // cause priority: power loss, then watchdog, then external
      if (power_lost_evt)
         s_next.st.cause = CAUSE_POWER_LOSS;
      else if (s_reg.wd_restart)
         s_next.st.cause = CAUSE_WATCHDOG;
      else if (ext_reset_evt)
         s_next.st.cause = CAUSE_EXT_RESET;
      if (temp_valid) begin
         if (cpu_temp < s_reg.st.cpu_tmin)
            s_next.st.cpu_tmin = cpu_temp;
         if (cpu_temp > s_reg.st.cpu_tmax)
            s_next.st.cpu_tmax = cpu_temp;
         if (brd_temp < s_reg.st.brd_tmin)
            s_next.st.brd_tmin = brd_temp;
         if (brd_temp > s_reg.st.brd_tmax)
            s_next.st.brd_tmax = brd_temp;
      end
      // current sampling; slot wraps so positions carry no age
      if (at_end(s_reg.samp_cnt, SAMPLE_CYCLES)) begin
         s_next.samp_cnt = '0;
         s_next.cur[s_reg.samp_slot*16 +: 16] =
            adc_data[`CUR_CHANNEL];
         s_next.samp_slot = s_reg.samp_slot + 2'h1;
      end else begin
         s_next.samp_cnt = s_reg.samp_cnt + 32'h1;
      end
      // exception code: latest wins, no clear path
      if (fault_evt)
         s_next.st.exc_code = fault_code;
      // blink: code pulses then a gap, halves of BLINK_CYCLES
      if (s_reg.st.exc_code == `CODE_NO_FAULT) begin
         s_next.blink_cnt = '0;
         s_next.blink_half = '0;
         s_next.led = 1'b0;
      end else if (at_end(s_reg.blink_cnt, BLINK_CYCLES)) begin
         s_next.blink_cnt = '0;
         if (s_reg.blink_half ==
             code_halves(s_reg.st.exc_code) + 6'(`GAP_HALVES - 1))
            s_next.blink_half = '0;
         else
            s_next.blink_half = s_reg.blink_half + 6'h1;
         s_next.led = !s_next.blink_half[0] &&
            (s_next.blink_half < code_halves(s_reg.st.exc_code));
      end else begin
         s_next.blink_cnt = s_reg.blink_cnt + 32'h1;
      end
      // clear before any new trip, so a trip in this cycle stays pending
      if (s_reg.wd_pending && supply_ok_4v2)
         s_next.wd_pending = 1'b0;
      // watchdog seconds countdown; undervoltage forces expiry
      if (s_reg.wd_on && at_end(s_reg.sec_cnt, SEC_CYCLES)) begin
         if (s_reg.wd_left == 16'h0001) begin
            s_next.wd_on = 1'b0;
            s_next.wd_restart = 1'b1;
            s_next.wd_pending = 1'b1;
         end else begin
            s_next.wd_left = s_reg.wd_left - 16'h1;
         end
      end
      if (s_reg.wd_on && undervolt) begin
         s_next.wd_on = 1'b0;
         s_next.wd_restart = 1'b1;
         s_next.wd_pending = 1'b1;
      end
      // host functions
      if (req.valid) begin
         s_next.rsp.valid = 1'b1;
         unique case (req.func)
            F_NOP: ;
            F_GET_VOLT: begin
               if (req.chan == `CUR_CHANNEL || req.chan == 3'h0)
                  s_next.rsp.err = 1'b1;
               else begin
                  s_next.rsp.b0_hi = hi(adc_data[req.chan]);
                  s_next.rsp.b0_lo = lo(adc_data[req.chan]);
               end
            end
            F_GET_CUR: begin
               s_next.rsp.b0_hi = hi(s_reg.cur[15:0]);
               s_next.rsp.b0_lo = lo(s_reg.cur[15:0]);
               s_next.rsp.b1_hi = hi(s_reg.cur[31:16]);
               s_next.rsp.b1_lo = lo(s_reg.cur[31:16]);
               s_next.rsp.b2_hi = hi(s_reg.cur[47:32]);
               s_next.rsp.b2_lo = lo(s_reg.cur[47:32]);
               s_next.rsp.b3_hi = hi(s_reg.cur[63:48]);
               s_next.rsp.b3_lo = lo(s_reg.cur[63:48]);
            end
            F_WD_ARM: begin
               s_next.wd_on = 1'b1;
               s_next.wd_reload = (req.wd_sec == '0) ?
                  `WD_DEFAULT_SEC : req.wd_sec;
               s_next.wd_left = s_next.wd_reload;
               s_next.wd_led = 1'b0;
            end
            F_WD_REFRESH: begin
               if (s_reg.wd_on)
                  s_next.wd_left = s_reg.wd_reload;
               else
                  s_next.rsp.err = 1'b1;
            end
            F_WD_DISABLE: s_next.wd_on = 1'b0;
            F_MEM_RD: s_next.rsp.b0_lo = mem_q;
            F_MEM_WR: s_next.rsp.err = req.key_area && key_lock;
         endcase
      end
      // set after the host arm: a supply event must not be lost to it
      if (s_reg.wd_pending && supply_ok_4v2)
         s_next.wd_led = 1'b1;
   end

   // srst stands for power-on, so the volatile code clears here
   always_ff @(posedge clk) begin
      if (srst) begin
         s_reg <= '0;
         s_reg.st.cpu_tmin <= 8'hff;
         s_reg.st.brd_tmin <= 8'hff;
      end else begin
         s_reg <= s_next;
      end
   end

   assign resp               = s_reg.rsp;
   assign stat               = s_reg.st;
   assign status_indicator   = s_reg.led;
   assign watchdog_indicator = s_reg.wd_led;
   assign watchdog_restart   = s_reg.wd_restart;
endmodule : board_health_monitor

//--- verilog/health_cfg.svh
// Function
// - operating minutes counter while running
// - on-time seconds since last start
// - keep temperature min and max, persisted
// - boot count on hw, sw reset, power-up
// - record restart cause power, watchdog, external
// - one kilobyte customer storage region
// - 128 byte lockable key region
// - voltage reading sixteen bits, high/low bytes
// - channels raw counts, 4 and 6 scaled
// - channel 7 only via current function
// - current read returns four samples
// - new current sample every 250 ms
// - sample slots not in time order
// - current step 8.06 mA per count
// - blink exception code on status indicator
// - flags hold last exception code
// - code volatile, no clear command
// - watchdog arm, refresh, disable requests
// - undervoltage trips watchdog; indicator lit above 4.2V
// Purpose: constants of the board health monitor
// Assumes: 100 MHz clock
// Notes:   scale factors are host-side arithmetic
`ifndef HEALTH_CFG_SVH
`define HEALTH_CFG_SVH
`define CLK_HZ            100000000
`define SAMPLE_MS         250
`define SAMPLE_CYC        ((`CLK_HZ / 1000) * `SAMPLE_MS)
`define SEC_CYC           (`CLK_HZ)
`define SEC_PER_MIN       60
`define BLINK_MS          250
`define BLINK_CYC         ((`CLK_HZ / 1000) * `BLINK_MS)
`define GAP_HALVES        8
`define CUST_BYTES        1024
`define KEY_BYTES         128
`define CUR_CHANNEL       3'h7
`define CODE_NO_FAULT              5'h00
`define CODE_MISSING_SUSPEND_CLOCK 5'h02
`define CODE_POWER_UP_MISSING      5'h03
`define CODE_POWER_FAIL            5'h08
`define CODE_THERMAL_TRIP          5'h14
`define WD_DEFAULT_SEC    16'h003c
`endif

//--- verilog/health_pkg.sv
// Purpose: types of the board health monitor
// Assumes: nothing
// Notes:   none
package health_pkg;
   typedef enum logic [1:0] {CAUSE_NONE, CAUSE_POWER_LOSS,
                             CAUSE_WATCHDOG, CAUSE_EXT_RESET} cause_t;
   typedef enum logic [2:0] {F_NOP, F_GET_VOLT, F_GET_CUR, F_WD_ARM,
                             F_WD_REFRESH, F_WD_DISABLE, F_MEM_RD,
                             F_MEM_WR} func_t;
   typedef struct packed {
      logic        valid;
      func_t       func;
      logic [2:0]  chan;
      logic [10:0] addr;
      logic        key_area;
      logic [7:0]  wdata;
      logic [15:0] wd_sec;
   } req_t;
   typedef struct packed {
      logic        valid;
      logic        err;
      logic [7:0]  b0_hi, b0_lo, b1_hi, b1_lo;
      logic [7:0]  b2_hi, b2_lo, b3_hi, b3_lo;
   } resp_t;
   typedef struct packed {
      logic [31:0] run_minutes;
      logic [31:0] on_seconds;
      logic [15:0] boot_count;
      cause_t      cause;
      logic [4:0]  exc_code;
      logic [7:0]  cpu_tmin, cpu_tmax, brd_tmin, brd_tmax;
   } stat_t;
endpackage : health_pkg

//--- tb/health_checker.sv
// Purpose: port assertions for board_health_monitor
// Assumes: one clock, srst synchronous
// Notes: voltage value is read from the b0 bytes
`timescale 1ns/1ps
module health_checker
   import health_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        load_persist,
   input wire logic        hw_reset_evt,
   input wire logic        sw_reset_evt,
   input wire logic        power_up_ok,
   input wire logic [15:0] adc_data [0:7],
   input wire logic        fault_evt,
   input wire logic [4:0]  fault_code,
   input wire logic        supply_ok_4v2,
   input wire req_t        req,
   input wire resp_t       resp,
   input wire stat_t       stat,
   input wire logic        status_indicator,
   input wire logic        watchdog_indicator
);
   logic [15:0] volt_reg;
   logic        boot;
   assign boot = hw_reset_evt | sw_reset_evt | power_up_ok;
   // channel captured at the request edge, compared one edge later
   always_ff @(posedge clk) volt_reg <= adc_data[req.chan];
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_ans; req.valid |=> resp.valid; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_volt; req.valid && req.func == F_GET_VOLT && req.chan
      inside {[1:6]} |=> {resp.b0_hi, resp.b0_lo} == volt_reg; endproperty
   a_volt: assert property (p_volt) else $error("bad volt");
   property p_cur7; req.valid && req.func == F_GET_VOLT
      && req.chan == 3'h7 |=> resp.err; endproperty
   a_cur7: assert property (p_cur7) else $error("ch7 as volt");
   property p_code; fault_evt |=> stat.exc_code == $past(fault_code);
   endproperty
   a_code: assert property (p_code) else $error("code lost");
   property p_keep; !fault_evt |=> $stable(stat.exc_code); endproperty
   a_keep: assert property (p_keep) else $error("code moved");
   property p_boot; boot && !load_persist
      |=> stat.boot_count == $past(stat.boot_count) + 16'h1; endproperty
   a_boot: assert property (p_boot) else $error("boot count");
   property p_wdi; $rose(watchdog_indicator) |-> $past(supply_ok_4v2);
   endproperty
   a_wdi: assert property (p_wdi) else $error("early wd led");
   property p_dark; (stat.exc_code == 5'h00) [*3] |-> !status_indicator;
   endproperty
   a_dark: assert property (p_dark) else $error("blink on 0");
   cover property (req.valid && req.func == F_GET_CUR);
   cover property (fault_evt);
   cover property ($rose(watchdog_indicator));
endmodule : health_checker

//--- tb/host_model.sv
// Purpose: host issuing one request at a time
// Assumes: answer one edge after the request
// Notes: wd_sec fixed at 2 to keep expiry short
`timescale 1ns/1ps
module host_model
   import health_pkg::*;
(
   input  wire logic  clk,
   output req_t       req,
   input  wire resp_t resp
);
   resp_t got;
   initial req = '0;
   task automatic ask(input func_t f, input logic [2:0] c,
                      input logic [10:0] a, input logic k,
                      input logic [7:0] d);
      @(negedge clk);
      req <= '{1'b1, f, c, a, k, d, 16'h0002};
      @(posedge clk);
      // answer stands for the cycle after the taking edge
      @(negedge clk);
      got = resp;
      req.valid <= 1'b0;
   endtask : ask
endmodule : host_model

//--- tb/board_health_monitor_bench.sv
// Purpose: self-checking bench of board_health_monitor
// Assumes: second 10, sample 20, blink half 4 cycles
// Notes: stimulus moves at falling edges
`timescale 1ns/1ps
module board_health_monitor_bench
   import health_pkg::*;
;
   logic        clk, srst, load_persist, running, hw_reset_evt;
   logic        sw_reset_evt, power_up_ok, ext_reset_evt, power_lost_evt;
   logic        temp_valid, fault_evt, undervolt, supply_ok_4v2, key_lock;
   logic [7:0]  cpu_temp, brd_temp;
   logic [4:0]  fault_code;
   logic [15:0] adc_data [0:7];
   stat_t       persist_in, stat;
   req_t        req;
   resp_t       resp, r;
   logic        status_indicator, watchdog_indicator, watchdog_restart;
   int          failures = 0, checks_done = 0, cycles = 0;
   board_health_monitor #(.SAMPLE_CYCLES(20), .SEC_CYCLES(10),
      .BLINK_CYCLES(4)) board_health_monitor_i (.clk, .srst, .load_persist,
      .persist_in, .running, .hw_reset_evt, .sw_reset_evt, .power_up_ok,
      .ext_reset_evt, .power_lost_evt, .cpu_temp, .brd_temp, .temp_valid,
      .adc_data, .fault_evt, .fault_code, .undervolt, .supply_ok_4v2,
      .key_lock, .req, .resp, .stat, .status_indicator, .watchdog_indicator,
      .watchdog_restart);
   host_model host_model_i (.clk, .req, .resp);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
   endtask : pulse
   // copy the answer here so checks never race a continuous assign
   task automatic ask(input func_t f, input logic [2:0] c,
                      input logic [10:0] a, input logic k,
                      input logic [7:0] d);
      host_model_i.ask(f, c, a, k, d);
      r = host_model_i.got;
   endtask : ask
   task automatic op(input func_t f);
      ask(f, 3'h0, 11'h000, 1'b0, 8'h00);
   endtask : op
   task automatic t_volt;
      for (int c = 0; c < 8; c++) begin
         ask(F_GET_VOLT, 3'(c), 11'h000, 1'b0, 8'h00);
         chk(r.err, c == 0 || c == 7);
         if (c > 0 && c < 7)
            chk({r.b0_hi, r.b0_lo}, adc_data[c]);
      end
      $display("voltage test finished");
   endtask : t_volt
   task automatic t_cur(input logic [15:0] nw, old, input int lo, hi);
      logic [63:0] v;
      int n;
      int o;
      op(F_GET_CUR);
      v = {r.b0_hi, r.b0_lo, r.b1_hi, r.b1_lo,
           r.b2_hi, r.b2_lo, r.b3_hi, r.b3_lo};
      n = 0;
      o = 0;
      for (int i = 0; i < 4; i++) begin
         n += (v[16*i +: 16] === nw);
         o += (v[16*i +: 16] === old);
      end
      chk(n >= lo && n <= hi && (n + o == 4 || nw == old), 1);
      $display("current test finished");
   endtask : t_cur
   task automatic t_time;
      logic [31:0] m, s;
      @(negedge clk);
      m = stat.run_minutes;
      s = stat.on_seconds;
      repeat (600) @(negedge clk);
      chk(stat.run_minutes - m, 1);
      chk(stat.on_seconds - s, 60);
      running = 1'b0;
      m = stat.run_minutes;
      repeat (600) @(negedge clk);
      chk(stat.run_minutes - m, 0);
      running = 1'b1;
      $display("time test finished");
   endtask : t_time
   task automatic t_boot;
      logic [15:0] b;
      b = stat.boot_count;
      pulse(hw_reset_evt);
      pulse(sw_reset_evt);
      pulse(power_up_ok);
      chk(stat.boot_count, 16'(b + 16'h3));
      chk(stat.on_seconds < 2, 1);
      $display("boot test finished");
   endtask : t_boot
   task automatic t_fault;
      logic [4:0] codes [4] = '{5'h02, 5'h03, 5'h08, 5'h14};
      int n;
      logic p;
      foreach (codes[i]) begin
         fault_code = codes[i];
         pulse(fault_evt);
         chk(stat.exc_code, codes[i]);
         // let the old pattern run out before counting one full period
         repeat (200) @(negedge clk);
         n = 0;
         p = status_indicator;
         repeat ((2 * codes[i] + 8) * 4) begin
            @(negedge clk);
            n += (status_indicator && !p);
            p = status_indicator;
         end
         chk(n, codes[i]);
      end
      $display("blink test finished");
   endtask : t_fault
   task automatic t_mem;
      ask(F_MEM_WR, 3'h0, 11'h3ff, 1'b0, 8'h5a);
      ask(F_MEM_RD, 3'h0, 11'h3ff, 1'b0, 8'h00);
      chk(r.b0_lo, 8'h5a);
      ask(F_MEM_WR, 3'h0, 11'h07f, 1'b1, 8'h33);
      key_lock <= 1'b1;
      ask(F_MEM_WR, 3'h0, 11'h07f, 1'b1, 8'hcc);
      chk(r.err, 1);
      ask(F_MEM_RD, 3'h0, 11'h07f, 1'b1, 8'h00);
      chk(r.b0_lo, 8'h33);
      $display("storage test finished");
   endtask : t_mem
   task automatic wait_rs(input int lim, output bit hit);
      hit = 0;
      repeat (lim) @(negedge clk) hit |= watchdog_restart;
   endtask : wait_rs
   task automatic t_wd;
      bit hit;
      op(F_WD_REFRESH);
      chk(r.err, 1);
      op(F_WD_ARM);
      op(F_WD_REFRESH);
      chk(r.err, 0);
      wait_rs(40, hit);
      chk(hit, 1);
      chk(stat.cause, CAUSE_WATCHDOG);
      op(F_WD_ARM);
      op(F_WD_DISABLE);
      wait_rs(40, hit);
      chk(hit, 0);
      op(F_WD_ARM);
      undervolt <= 1'b1;
      wait_rs(4, hit);
      chk(hit, 1);
      undervolt = 1'b0;
      chk(watchdog_indicator, 0);
      supply_ok_4v2 = 1'b1;
      repeat (3) @(negedge clk);
      chk(watchdog_indicator, 1);
      $display("watchdog test finished");
   endtask : t_wd
   task automatic temp(input logic [7:0] c, b);
      cpu_temp = c;
      brd_temp = b;
      pulse(temp_valid);
   endtask : temp
   task automatic t_misc;
      pulse(power_lost_evt);
      chk(stat.cause, CAUSE_POWER_LOSS);
      pulse(ext_reset_evt);
      chk(stat.cause, CAUSE_EXT_RESET);
      temp(8'h28, 8'h32);
      temp(8'h0a, 8'h5a);
      temp(8'h1e, 8'h14);
      chk({stat.cpu_tmin, stat.cpu_tmax, stat.brd_tmin, stat.brd_tmax},
          32'h0a28145a);
      persist_in.boot_count = 16'h0123;
      persist_in.cpu_tmin = 8'h05;
      pulse(load_persist);
      chk(stat.boot_count, 16'h0123);
      chk(stat.cpu_tmin, 8'h05);
      $display("cause and temperature test finished");
   endtask : t_misc
   task automatic test_done;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   // whole run is near 2700 cycles; the ceiling leaves ample room
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         failures++;
         test_done();
      end
   end
   initial begin
      {srst, load_persist, running, hw_reset_evt, sw_reset_evt} = 5'h14;
      {power_up_ok, ext_reset_evt, power_lost_evt, temp_valid} = 4'h0;
      {fault_evt, undervolt, supply_ok_4v2, key_lock} = 4'h0;
      {cpu_temp, brd_temp, fault_code} = '0;
      persist_in = '0;
      for (int i = 0; i < 8; i++)
         adc_data[i] = 16'(i * 16'h0091);
      adc_data[7] = 16'h02aa;
      repeat (20) @(negedge clk);
      srst = 1'b0;
      t_volt();
      repeat (100) @(negedge clk);
      t_cur(16'h02aa, 16'h02aa, 4, 4);
      adc_data[7] = 16'h0155;
      repeat (50) @(negedge clk);
      t_cur(16'h0155, 16'h02aa, 2, 3);
      t_time();
      t_boot();
      t_fault();
      t_mem();
      t_wd();
      t_misc();
      test_done();
   end
endmodule : board_health_monitor_bench
bind board_health_monitor health_checker health_checker_i (.clk, .srst,
   .load_persist, .hw_reset_evt, .sw_reset_evt, .power_up_ok, .adc_data,
   .fault_evt, .fault_code, .supply_ok_4v2, .req, .resp, .stat,
   .status_indicator, .watchdog_indicator);
